// *** plc_delay_timer_bank_params.svh ***
// What this block does
// - On-delay timers count ticks only while gated.
// - On-delay output set when count reaches preset.
// - Plain on-delay count clears when gate drops.
// - Retentive count holds while gate is low.
// - Only clear command or reset zeroes a retentive count.
// - On-delay counts saturate at 32767, never wrap.
// - Delayed-release gate high: output on, count zero.
// - Delayed-release counts to preset, then output off.
// - Short gate-low gap keeps delayed-release output on.
// - Delayed-release starts only on a falling gate.
// - Inactive step region idles delayed-release timers.
// - One count unit equals one time-base tick.
// - Retentive indices and their tick resolutions.
// - Non-retentive indices and their tick resolutions.
// - Clear command drops output and zeroes count.
// - Cleared delayed-release waits for a falling gate.
// - Reset starts every timer off at zero.
`ifndef PLC_DELAY_TIMER_BANK_PARAMS_SVH
`define PLC_DELAY_TIMER_BANK_PARAMS_SVH

// Size of the bank.
`define NUM_TIMERS        256
`define NUM_OUT_WORDS     8

// Register areas, selected by address bits 11:10.
`define PRESET_BASE       12'h000
`define COUNT_BASE        12'h400
`define CTRL_BASE         12'h800
`define OUTBITS_BASE      12'hc00

// Control word fields.
`define CTRL_GATE_BIT     0
`define CTRL_OFFDLY_BIT   1
`define CTRL_REGION_BIT   2
`define CTRL_CLEAR_BIT    3
`define CTRL_OUT_BIT      4
`define CTRL_RUN_BIT      5

// Reset values.
`define PRESET_RESET      16'h0000
`define COUNT_RESET       16'h0000
`define CTRL_RESET        3'h4

// Counting limits and time base.
`define COUNT_MAX         16'h7fff
`define CLK_PERIOD_NS     10
`define TIME_BASE_1MS_NS  1000000
`define MS_PER_10MS       10
`define MS_PER_100MS      100

`endif

// *** plc_delay_timer_bank_pkg.sv ***
`include "plc_delay_timer_bank_params.svh"

package plc_delay_timer_bank_pkg;

	// Time base of a timer, one-hot.
	typedef enum logic [2:0] {
		RES_1MS   = 3'h1,
		RES_10MS  = 3'h2,
		RES_100MS = 3'h4
	} res_e;

	// Phase of a delayed-release timer, one-hot.
	typedef enum logic [2:0] {
		OFF_IDLE   = 3'h1,
		OFF_HOLD   = 3'h2,
		OFF_TIMING = 3'h4
	} offdly_state_e;

	// Register area decoded from the address.
	typedef enum logic [1:0] {
		AREA_PRESET = 2'(`PRESET_BASE >> 10),
		AREA_COUNT  = 2'(`COUNT_BASE >> 10),
		AREA_CTRL   = 2'(`CTRL_BASE >> 10),
		AREA_OUT    = 2'(`OUTBITS_BASE >> 10)
	} reg_area_e;

	// Stored control bits of one timer.
	typedef struct packed {
		logic regionActive;
		logic offDelay;
		logic gate;
	} timer_ctrl_s;

	// Time-base strobes, each one clock cycle long.
	typedef struct packed {
		logic t100;
		logic t10;
		logic t1;
	} tick_s;

endpackage : plc_delay_timer_bank_pkg

// *** plc_delay_timer_bank.sv ***
`timescale 1ns/100ps

module plc_delay_timer_bank
	import plc_delay_timer_bank_pkg::*;
#(
	parameter int CYCLES_PER_MS = `TIME_BASE_1MS_NS / `CLK_PERIOD_NS
) (
	input  wire logic                      clk_sys,  // System clock, 100 MHz.
	input  wire logic                      rst,      // Synchronous reset, active high.
	input  wire logic                      psel,     // APB select.
	input  wire logic                      penable,  // APB access phase.
	input  wire logic                      pwrite,   // APB direction, high for write.
	input  wire logic [11:0]               paddr,    // APB byte address.
	input  wire logic [31:0]               pwdata,   // APB write data.
	output logic      [31:0]               prdata,   // APB read data.
	output logic                           pready,   // APB ready.
	output logic                           pslverr,  // APB error.
	output logic      [`NUM_TIMERS-1:0]    timerOut  // Timer output bits, one per timer.
);

	// Resolution of a timer follows from its index alone.
	function automatic res_e resOf(input int idx);
		logic [4:0] low;
		low = 5'(idx);
		if (idx >= 128) begin
			resOf = RES_100MS;
		end else if (low == 5'h00) begin
			resOf = RES_1MS;
		end else if (low <= 5'h04) begin
			resOf = RES_10MS;
		end else begin
			resOf = RES_100MS;
		end
	endfunction : resOf

	// Indices 0-31 and 64-95 are retentive, the rest are not.
	function automatic logic isRetentive(input int idx);
		isRetentive = (idx < 128) && (((idx >> 5) & 1) == 0);
	endfunction : isRetentive

	// Picks the strobe that matches a time base.
	function automatic logic tickFor(input res_e res, input tick_s t);
		unique case (res)
			RES_1MS:   tickFor = t.t1;
			RES_10MS:  tickFor = t.t10;
			RES_100MS: tickFor = t.t100;
		endcase
	endfunction : tickFor

	// Register area of an address.
	function automatic reg_area_e areaOf(input logic [11:0] a);
		areaOf = reg_area_e'(a[11:10]);
	endfunction : areaOf

	// Register state.
	logic signed [15:0]           presetQ   [`NUM_TIMERS]; // Preset value per timer.
	logic signed [15:0]           countQ    [`NUM_TIMERS]; // Current count per timer.
	timer_ctrl_s                  ctrlQ     [`NUM_TIMERS]; // Gate, mode and region bits.
	offdly_state_e                offStateQ [`NUM_TIMERS]; // Delayed-release phase.
	logic [`NUM_TIMERS-1:0]       clearQ;                  // One-cycle clear commands.
	logic [`NUM_TIMERS-1:0]       bitQ;                    // Timer output bits.
	logic [31:0]                  msCntQ;                  // Clock cycles within one millisecond.
	logic [7:0]                   div10Q;                  // Milliseconds within ten.
	logic [7:0]                   div100Q;                 // Milliseconds within a hundred.
	tick_s                        tickQ;                   // Registered time-base strobes.
	logic                         preadyQ;                 // Ready flop.
	logic [31:0]                  prdataQ;                 // Read data flop.
	logic                         pslverrQ;                // Error flop.

	// Bus decode.
	logic                         xferDone;                // Access completes at this edge.
	logic                         accessWait;              // Access phase, answer not yet given.
	reg_area_e                    area;                    // Addressed area.
	logic [7:0]                   idx;                     // Addressed word within the area.
	logic                         badAccess;               // Unmapped or read-only target.

	assign xferDone   = psel & penable & preadyQ;
	assign accessWait = psel & penable & ~preadyQ;
	assign area       = areaOf(paddr);
	assign idx        = paddr[9:2];
	assign badAccess  = ((area == AREA_OUT) && (idx >= 8'(`NUM_OUT_WORDS)))
	                  | (pwrite && ((area == AREA_COUNT) || (area == AREA_OUT)));

	// Outputs come straight from their flops.
	assign prdata   = prdataQ;
	assign pready   = preadyQ;
	assign pslverr  = pslverrQ;
	assign timerOut = bitQ;

	// Millisecond prescaler; the period is a parameter so that a simulation can shorten it.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			msCntQ <= 32'h00000000;
		end else if (msCntQ == 32'(CYCLES_PER_MS - 1)) begin
			msCntQ <= 32'h00000000;
		end else begin
			msCntQ <= msCntQ + 32'h00000001;
		end
	end

	// Decade dividers advance once per millisecond so that all three bases stay in phase.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div10Q  <= 8'h00;
			div100Q <= 8'h00;
		end else if (msCntQ == 32'(CYCLES_PER_MS - 1)) begin
			div10Q  <= (div10Q == 8'(`MS_PER_10MS - 1)) ? 8'h00 : div10Q + 8'h01;
			div100Q <= (div100Q == 8'(`MS_PER_100MS - 1)) ? 8'h00 : div100Q + 8'h01;
		end
	end

	// Strobes are registered, so each lasts exactly one cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tickQ <= '0;
		end else begin
			tickQ.t1   <= (msCntQ == 32'(CYCLES_PER_MS - 1));
			tickQ.t10  <= (msCntQ == 32'(CYCLES_PER_MS - 1)) && (div10Q == 8'(`MS_PER_10MS - 1));
			tickQ.t100 <= (msCntQ == 32'(CYCLES_PER_MS - 1)) && (div100Q == 8'(`MS_PER_100MS - 1));
		end
	end

	// Ready rises one cycle into the access phase, giving every access one wait state.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			preadyQ <= 1'b0;
		end else begin
			preadyQ <= accessWait;
		end
	end

	// Error answer is prepared with ready and dropped after the transfer.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pslverrQ <= 1'b0;
		end else begin
			pslverrQ <= accessWait & badAccess;
		end
	end

	// Read data is captured in the wait cycle, so it shows state one edge before completion.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prdataQ <= 32'h00000000;
		end else if (accessWait && !pwrite && !badAccess) begin
			unique case (area)
				AREA_PRESET: begin
					prdataQ <= {16'h0000, presetQ[idx]};
				end
				AREA_COUNT: begin
					prdataQ <= {16'h0000, countQ[idx]};
				end
				AREA_CTRL: begin
					// The clear bit is a command and always reads back as zero.
					prdataQ                   <= 32'h00000000;
					prdataQ[`CTRL_GATE_BIT]   <= ctrlQ[idx].gate;
					prdataQ[`CTRL_OFFDLY_BIT] <= ctrlQ[idx].offDelay;
					prdataQ[`CTRL_REGION_BIT] <= ctrlQ[idx].regionActive;
					prdataQ[`CTRL_OUT_BIT]    <= bitQ[idx];
					prdataQ[`CTRL_RUN_BIT]    <= (offStateQ[idx] == OFF_TIMING);
				end
				AREA_OUT: begin
					prdataQ <= bitQ[{idx[2:0], 5'h00} +: 32];
				end
			endcase
		end else begin
			prdataQ <= 32'h00000000;
		end
	end

	// One register slice and one timing engine per timer.
	for (genvar g = 0; g < `NUM_TIMERS; g++) begin : gTimer
		localparam res_e RES = resOf(g);
		localparam logic RET = isRetentive(g);

		logic               wrHere;   // Completed write to this timer's word.
		logic               tickHere; // Strobe of this timer's time base.
		logic signed [15:0] countInc; // Count plus one tick.
		logic               atMax;    // Count has reached its ceiling.

		assign wrHere   = xferDone & pwrite & ~pslverrQ & (idx == 8'(g));
		assign tickHere = tickFor(RES, tickQ);
		assign countInc = countQ[g] + 16'sh0001;
		assign atMax    = (countQ[g] == `COUNT_MAX);

		// Preset is written only by software.
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				presetQ[g] <= `PRESET_RESET;
			end else if (wrHere && (area == AREA_PRESET)) begin
				presetQ[g] <= pwdata[15:0];
			end
		end

		// Control bits; the mode bit is ignored on retentive indices since their kind is fixed.
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				ctrlQ[g] <= `CTRL_RESET;
			end else if (wrHere && (area == AREA_CTRL)) begin
				ctrlQ[g].gate         <= pwdata[`CTRL_GATE_BIT];
				ctrlQ[g].offDelay     <= pwdata[`CTRL_OFFDLY_BIT];
				ctrlQ[g].regionActive <= pwdata[`CTRL_REGION_BIT];
			end
		end

		// Clear is a pulse that acts on the edge after the write completes.
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				clearQ[g] <= 1'b0;
			end else begin
				clearQ[g] <= wrHere && (area == AREA_CTRL) && pwdata[`CTRL_CLEAR_BIT];
			end
		end

		// Timing engine; reset zeroes every count, retentive ones included.
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				countQ[g]    <= `COUNT_RESET;
				bitQ[g]      <= 1'b0;
				offStateQ[g] <= OFF_IDLE;
			end else if (clearQ[g]) begin
				// Clear beats everything; a delayed-release timer then waits for a new fall.
				countQ[g]    <= `COUNT_RESET;
				bitQ[g]      <= 1'b0;
				offStateQ[g] <= OFF_IDLE;
			end else if (!RET && ctrlQ[g].offDelay) begin
				if (!ctrlQ[g].regionActive) begin
					// Step region off: parked at zero, output off, no counting.
					countQ[g]    <= `COUNT_RESET;
					bitQ[g]      <= 1'b0;
					offStateQ[g] <= OFF_IDLE;
				end else begin
					unique case (offStateQ[g])
						OFF_IDLE: begin
							// A low gate alone never starts timing.
							if (ctrlQ[g].gate) begin
								countQ[g]    <= `COUNT_RESET;
								bitQ[g]      <= 1'b1;
								offStateQ[g] <= OFF_HOLD;
							end
						end
						OFF_HOLD: begin
							countQ[g] <= `COUNT_RESET;
							bitQ[g]   <= 1'b1;
							if (!ctrlQ[g].gate) begin
								// High-to-low seen; a preset at or below zero releases at once.
								if (presetQ[g] <= 16'sh0000) begin
									bitQ[g]      <= 1'b0;
									offStateQ[g] <= OFF_IDLE;
								end else begin
									offStateQ[g] <= OFF_TIMING;
								end
							end
						end
						OFF_TIMING: begin
							if (ctrlQ[g].gate) begin
								// Gate back before expiry: output never dropped.
								countQ[g]    <= `COUNT_RESET;
								bitQ[g]      <= 1'b1;
								offStateQ[g] <= OFF_HOLD;
							end else if (countQ[g] >= presetQ[g]) begin
								// Preset lowered under the count while timing.
								bitQ[g]      <= 1'b0;
								offStateQ[g] <= OFF_IDLE;
							end else if (tickHere) begin
								countQ[g] <= countInc;
								if (countInc >= presetQ[g]) begin
									bitQ[g]      <= 1'b0;
									offStateQ[g] <= OFF_IDLE;
								end
							end
						end
					endcase
				end
			end else begin
				offStateQ[g] <= OFF_IDLE;
				if (ctrlQ[g].gate) begin
					// Counting only under the gate, held at the ceiling.
					if (tickHere && !atMax) begin
						countQ[g] <= countInc;
						bitQ[g]   <= (countInc >= presetQ[g]);
					end else begin
						bitQ[g]   <= (countQ[g] >= presetQ[g]);
					end
				end else if (!RET) begin
					countQ[g] <= `COUNT_RESET;
					bitQ[g]   <= 1'b0;
				end
				// A retentive timer with its gate low keeps count and output as they stand.
			end
		end
	end

endmodule : plc_delay_timer_bank

// *** plc_exec_engine.sv ***
`timescale 1ns/100ps

module plc_exec_engine (
	input  wire logic        clk_sys,  // System clock.
	output logic             psel,     // Select.
	output logic             penable,  // Access phase.
	output logic             pwrite,   // Direction.
	output logic      [11:0] paddr,    // Byte address.
	output logic      [31:0] pwdata,   // Write data.
	input  wire logic [31:0] prdata,   // Read data.
	input  wire logic        pready,   // Ready.
	input  wire logic        pslverr   // Error.
);
	// The bus starts idle.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// One transfer, held until ready is seen at an edge.
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Stale data is inverted so it never looks valid.
		pwdata <= ~d;
	endtask : xfer
endmodule : plc_exec_engine

// *** plc_delay_timer_bank_props.sv ***
`timescale 1ns/100ps
`include "plc_delay_timer_bank_params.svh"

module plc_delay_timer_bank_props
	import plc_delay_timer_bank_pkg::*;
#(
	parameter int CYCLES_PER_MS = 100000
) (
	input wire logic                   clk_sys,   // Clock.
	input wire logic                   rst,       // Reset.
	input wire logic                   psel,      // Select.
	input wire logic                   penable,   // Access.
	input wire logic                   pwrite,    // Direction.
	input wire logic [11:0]            paddr,     // Address.
	input wire logic [31:0]            pwdata,    // Write data.
	input wire logic [31:0]            prdata,    // Read data.
	input wire logic                   pready,    // Ready.
	input wire logic                   pslverr,   // Error.
	input wire logic [`NUM_TIMERS-1:0] timerOut   // Timer bits.
);
	logic       xferDone;  // A transfer completes at this edge.
	logic       ctrlHit_q; // A control write completed last edge.
	logic [7:0] ctrlIdx_q; // Its timer index.
	logic [3:0] ctrlDat_q; // Its low control bits.

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	assign xferDone = psel && penable && pready;

	// Control writes are kept so later outputs can be tied to them.
	always_ff @(posedge clk_sys) begin
		ctrlHit_q <= !rst && xferDone && pwrite && paddr[11:10] == 2'h2;
		if (xferDone && pwrite && paddr[11:10] == 2'h2) begin
			ctrlIdx_q <= paddr[9:2];
			ctrlDat_q <= pwdata[3:0];
		end
	end

	a_reset_clears: assert property (disable iff (1'b0) rst |=> timerOut == '0 && !pready)
		else $error("outputs not cleared by reset");
	a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_quiet_idle: assert property (!pready |-> prdata == '0 && !pslverr)
		else $error("read data or error outside completion");
	a_refuse_access: assert property (xferDone && (pwrite && paddr[10] || paddr >= 12'hc20) |-> pslverr)
		else $error("bad access not refused");
	a_count_range: assert property (xferDone && !pwrite && paddr[11:10] == 2'h1 |-> prdata[31:15] == '0)
		else $error("count outside 0 to 32767");
	a_preset_width: assert property (xferDone && !pwrite && paddr[11:10] == 2'h0 |-> prdata[31:16] == '0)
		else $error("preset upper bits not zero");
	// Only non-retentive indices can run as delayed-release timers; retentive ones ignore the mode bit.
	a_release_on: assert property (ctrlHit_q && ctrlDat_q == 4'h7 && (ctrlIdx_q[7] || ctrlIdx_q[5]) |-> ##[0:3] timerOut[ctrlIdx_q])
		else $error("delayed-release bit not set by gate");
	a_clear_drops: assert property (ctrlHit_q && ctrlDat_q[3] && !ctrlDat_q[0] |-> ##[0:3] !timerOut[ctrlIdx_q])
		else $error("clear did not drop bit");
	a_region_idle: assert property (ctrlHit_q && ctrlDat_q == 4'h3 && (ctrlIdx_q[7] || ctrlIdx_q[5]) |-> ##[0:3] !timerOut[ctrlIdx_q])
		else $error("inactive region left bit set");

	c_refused: cover property (xferDone && pslverr);
	c_release: cover property (ctrlHit_q && ctrlDat_q == 4'h7);
	c_expire: cover property ($fell(timerOut[96]));
endmodule : plc_delay_timer_bank_props

bind plc_delay_timer_bank plc_delay_timer_bank_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (.clk_sys(clk_sys),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .timerOut(timerOut));

// *** tb_plc_delay_timer_bank.sv ***
`timescale 1ns/100ps
`include "plc_delay_timer_bank_params.svh"

module tb_plc_delay_timer_bank
	import plc_delay_timer_bank_pkg::*;
;
	// A short millisecond keeps 100 ms ticks inside the run.
	localparam int CPM = 10;
	logic                   clk_sys = 1'b0;
	logic                   rst = 1'b1;
	logic                   psel, penable, pwrite, pready, pslverr;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rv;
	logic [`NUM_TIMERS-1:0] timerOut;
	logic [31:0]            hv[13];
	int                     miscompares = 0;
	int                     comparisons = 0;
	int                     ix[13] = '{0, 4, 31, 32, 36, 63, 64, 68, 95, 96, 100, 101, 255};
	int                     pr[13] = '{1, 10, 100, 1, 10, 100, 1, 10, 100, 1, 10, 100, 100};

	plc_delay_timer_bank #(.CYCLES_PER_MS(CPM)) u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timerOut(timerOut));
	plc_exec_engine u_eng (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	always #5 clk_sys = ~clk_sys;

	// Exact value comparison.
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	// Range comparison, since tick phase is free against the bus.
	task cmpIn(input logic [31:0] got, input int lo, input int hi);
		comparisons++;
		if ((^got === 1'bx) || got < lo || got > hi) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h..%h", $time, got, lo, hi);
		end
	endtask : cmpIn

	function automatic logic [11:0] ad(input reg_area_e ar, input int i);
		return {ar, i[7:0], 2'h0};
	endfunction : ad

	// One access; the error flag is always checked.
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic e;
		u_eng.xfer(w, a, d, rv, e);
		cmp({31'h0, e}, {31'h0, ee});
	endtask : acc

	task wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt

	task wrC(input int i, input logic [31:0] d);
		acc(1'b1, ad(AREA_CTRL, i), d, 1'b0);
	endtask : wrC

	task rdCnt(input int i, input int lo, input int hi);
		acc(1'b0, ad(AREA_COUNT, i), 32'h0, 1'b0);
		cmpIn(rv, lo, hi);
	endtask : rdCnt

	task stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	// A hang counts as a failure.
	initial begin
		wt(20000);
		miscompares++;
		stop_test();
	end

	initial begin
		wt(12);
		rst <= 1'b0;
		for (int w = 0; w < 8; w++) begin
			acc(1'b0, ad(AREA_OUT, w), 32'h0, 1'b0);
			cmp(rv, 32'h0);
		end
		rdCnt(7, 0, 0);
		acc(1'b1, ad(AREA_COUNT, 7), 32'h1, 1'b1);
		acc(1'b0, 12'hc20, 32'h0, 1'b1);
		acc(1'b1, ad(AREA_PRESET, 9), 32'h12345, 1'b0);
		acc(1'b0, ad(AREA_PRESET, 9), 32'h0, 1'b0);
		cmp(rv, 32'h2345);
		acc(1'b1, ad(AREA_PRESET, 33), 32'hfff0, 1'b0);
		wrC(33, 5);
		wt(4);
		cmp(timerOut[33], 1);
		wrC(33, 4);
		$display("test registers done");
		// Every resolution band counts together for a fixed span.
		foreach (ix[k]) acc(1'b1, ad(AREA_PRESET, ix[k]), 32'd50, 1'b0);
		foreach (ix[k]) wrC(ix[k], 5);
		wt(2000);
		foreach (ix[k]) rdCnt(ix[k], 2040 / (CPM * pr[k]) - 1, 2080 / (CPM * pr[k]) + 1);
		foreach (ix[k]) cmp(timerOut[ix[k]], pr[k] == 1);
		foreach (ix[k]) wrC(ix[k], 4);
		wt(3);
		foreach (ix[k]) begin
			acc(1'b0, ad(AREA_COUNT, ix[k]), 32'h0, 1'b0);
			hv[k] = rv;
			if (ix[k] < 32 || (ix[k] >= 64 && ix[k] < 96))
				cmpIn(rv, 2040 / (CPM * pr[k]) - 1, 32767);
			else
				cmp(rv, 32'h0);
		end
		wt(300);
		foreach (ix[k]) rdCnt(ix[k], hv[k], hv[k]);
		wrC(0, 5);
		wt(100);
		wrC(0, 4);
		rdCnt(0, hv[0] + 8, hv[0] + 12);
		foreach (ix[k]) wrC(ix[k], 12);
		wt(3);
		foreach (ix[k]) rdCnt(ix[k], 0, 0);
		cmp({31'h0, |timerOut}, 32'h0);
		$display("test resolution done");
		// Index 96 is reused as delayed-release only after the clear above.
		acc(1'b1, ad(AREA_PRESET, 96), 32'd5, 1'b0);
		wrC(96, 7);
		wt(4);
		cmp(timerOut[96], 1);
		rdCnt(96, 0, 0);
		wrC(96, 6);
		wt(20);
		cmp(timerOut[96], 1);
		wrC(96, 7);
		wrC(96, 6);
		wt(80);
		cmp(timerOut[96], 0);
		rdCnt(96, 5, 5);
		wrC(96, 7);
		wrC(96, 6);
		wrC(96, 14);
		wt(80);
		cmp(timerOut[96], 0);
		rdCnt(96, 0, 0);
		wrC(96, 3);
		wt(4);
		cmp(timerOut[96], 0);
		wrC(96, 2);
		wt(80);
		rdCnt(96, 0, 0);
		$display("test delayed release done");
		stop_test();
	end
endmodule : tb_plc_delay_timer_bank
